// ==== design/mct_pkg.sv ====
// Shared constants and carrier types for the temperature target port.
// Assumes a 100 MHz system clock; bus pins arrive asynchronously.
package mct_pkg;

   // -----------------------------------------------------------------
   // Bus address and strap decoding
   // -----------------------------------------------------------------
   localparam logic [4:0] ADDR_HI        = 5'h12;  // Upper five address bits
   localparam logic [1:0] STRAP_GND      = 2'h0;
   localparam logic [1:0] STRAP_VDD      = 2'h1;
   localparam logic [1:0] STRAP_SDA      = 2'h2;
   localparam logic [1:0] STRAP_SCL      = 2'h3;

   // -----------------------------------------------------------------
   // Register pointers and field positions
   // -----------------------------------------------------------------
   localparam logic [7:0] PTR_LOCAL      = 8'h00;  // Remote channels follow
   localparam int         NUM_REMOTE     = 8;
   localparam logic [7:0] PTR_STATUS     = 8'h09;  // Remote open-fault flags
   localparam logic [7:0] PTR_CONFIG     = 8'h0a;
   localparam logic [7:0] PTR_HYST       = 8'h0b;
   localparam logic [7:0] PTR_LIMIT1     = 8'h0c;
   localparam logic [7:0] PTR_LIMIT2     = 8'h0d;
   localparam int         CFG_HALT_BIT   = 5;
   localparam int         TEMP_FRAC_LSB  = 3;      // Bits below read zero
   localparam int         TEMP_BITS      = 13;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [15:0] CONFIG_RST    = 16'h0000;
   localparam logic [15:0] HYST_RST      = 16'h0500;  // 10 degrees
   localparam logic [15:0] LIMIT1_RST    = 16'h5500;  // 170 degrees
   localparam logic [15:0] LIMIT2_RST    = 16'h5500;
   localparam logic [15:0] TEMP_SHORTED  = 16'h8000;  // -256 degrees

   // -----------------------------------------------------------------
   // Conversion timebase
   // -----------------------------------------------------------------
   localparam int CLK_MHZ                = 100;
   localparam int CONV_TIME_US           = 100;
   localparam int CONV_CYCLES            = CONV_TIME_US * CLK_MHZ;

   // -----------------------------------------------------------------
   // Carrier types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [TEMP_BITS-1:0] value;     // Two's complement, 1/16 degree
      logic                 shorted;   // Diode short seen
      logic                 open_flt;  // Fault comparator tripped
   } mct_sample_t;

   typedef struct packed {
      logic       start;
      logic       stop;
      logic       rise;
      logic       fall;
   } mct_bus_ev_t;

endpackage

// ==== design/mct_i2c_target.sv ====
// Two-wire target engine: start/stop, address match, pointer, word access.
// Assumes SCL and SDA already synchronised into clk_sys_i.
`timescale 1ns/1ps
module mct_i2c_target (
   input  wire logic                clk_sys_i,
   input  wire logic                rst_i,
   input  wire logic                scl_i,
   input  wire logic                sda_i,
   input  wire logic [6:0]          own_addr_i,
   input  wire logic [15:0]         rd_word_i,
   output logic                     sda_oe_o,
   output logic [7:0]               ptr_o,
   output logic                     wr_stb_o,
   output logic [15:0]              wr_word_o
);

   // ------------------------------------------------------------------
   // States
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_WR   = 3'b011,
      ST_RD   = 3'b010,
      ST_ACK  = 3'b110,
      ST_RACK = 3'b111
   } mct_state_t;

   mct_state_t  st_q, st_d;
   logic        scl_q, sda_q;
   logic [7:0]  sh_q;
   logic [3:0]  bit_q;
   logic [1:0]  wcnt_q;
   logic        rnw_q, nack_q, rbyte_q;
   logic [7:0]  ptr_q, hi_q;
   logic        oe_q, stb_q;
   logic [15:0] wword_q;

   // Edge and condition decode
   wire scl_rise = scl_i & ~scl_q;
   wire scl_fall = ~scl_i & scl_q;
   wire start_ev = scl_i & scl_q & sda_q & ~sda_i;
   wire stop_ev  = scl_i & scl_q & ~sda_q & sda_i;
   wire byte_end = (bit_q == 4'd8);
   wire addr_hit = (sh_q[7:1] == own_addr_i);
   wire [7:0] rd_byte = rbyte_q ? rd_word_i[7:0] : rd_word_i[15:8];
   wire [7:0] nx_byte = rbyte_q ? rd_word_i[15:8] : rd_word_i[7:0];  // Byte after controller ack

   assign sda_oe_o  = oe_q;        // never drives SCL
   assign ptr_o     = ptr_q;
   assign wr_stb_o  = stb_q;
   assign wr_word_o = wword_q;

   // Sampling pipeline
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   // Main protocol sequencer
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_q    <= ST_IDLE;
         sh_q    <= 8'h00;
         bit_q   <= 4'd0;
         wcnt_q  <= 2'd0;
         rnw_q   <= 1'b0;
         nack_q  <= 1'b0;
         rbyte_q <= 1'b0;
         ptr_q   <= 8'h00;
         hi_q    <= 8'h00;
         oe_q    <= 1'b0;
         stb_q   <= 1'b0;
         wword_q <= 16'h0000;
      end else begin
         stb_q <= 1'b0;
         if (start_ev) begin
            st_q   <= ST_ADDR;
            bit_q  <= 4'd0;
            wcnt_q <= 2'd0;                           // partial word dropped
            oe_q   <= 1'b0;
         end else if (stop_ev) begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
         end else begin
            case (st_q)
               ST_IDLE: begin
                  oe_q <= 1'b0;
               end
               ST_ADDR, ST_WR: begin
                  if (scl_rise && !byte_end) begin    // MSB first
                     sh_q  <= {sh_q[6:0], sda_i};
                     bit_q <= bit_q + 4'd1;
                  end
                  if (scl_fall && byte_end) begin
                     bit_q <= 4'd0;
                     if (st_q == ST_ADDR) begin
                        if (addr_hit) begin
                           oe_q    <= 1'b1;
                           rnw_q   <= sh_q[0];
                           rbyte_q <= 1'b0;
                           st_q    <= ST_ACK;
                        end else begin
                           st_q <= ST_IDLE;
                        end
                     end else begin
                        oe_q <= 1'b1;
                        st_q <= ST_ACK;
                        case (wcnt_q)
                           2'd0: ptr_q <= sh_q;
                           2'd1: hi_q  <= sh_q;
                           default: begin             // commit on ack
                              wword_q <= {hi_q, sh_q};
                              stb_q   <= 1'b1;
                           end
                        endcase
                        wcnt_q <= (wcnt_q == 2'd2) ? 2'd1 : wcnt_q + 2'd1;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (rnw_q) begin
                        st_q  <= ST_RD;
                        oe_q  <= ~rd_byte[7];
                        sh_q  <= {rd_byte[6:0], 1'b0};
                        bit_q <= 4'd1;
                     end else begin
                        st_q <= ST_WR;
                        oe_q <= 1'b0;
                     end
                  end
               end
               ST_RD: begin
                  if (scl_fall) begin
                     if (byte_end) begin
                        oe_q <= 1'b0;                 // Controller acks
                        st_q <= ST_RACK;
                     end else begin
                        oe_q  <= ~sh_q[7];
                        sh_q  <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'd1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     nack_q <= sda_i;
                  end
                  if (scl_fall) begin
                     if (nack_q) begin
                        st_q <= ST_IDLE;
                     end else begin
                        rbyte_q <= ~rbyte_q;
                        st_q    <= ST_RD;             // Next byte MSB on this fall
                        oe_q    <= ~nx_byte[7];
                        sh_q    <= {nx_byte[6:0], 1'b0};
                        bit_q   <= 4'd1;
                     end
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

endmodule // mct_i2c_target

// ==== design/mct_readout_top.sv ====
// Temperature readout top: results, faults, alerts, halt control, target port.
// Assumes analog results arrive as samples; pins are asynchronous.
//
// Overview of operation
// - Temperatures have 13 bits, one count is 0.0625 degrees.
// - Two-byte word, upper byte LSB is 2 degrees, low byte MSB is 1 degree, rest fractional.
// - Negative values in two's complement, span -256 to 255.9375.
// - Shorted remote diode returns -256 degrees code.
// - Open or miswired remote diode detected by supply comparator.
// - Comparator sampled all conversion; fault sets channel open flag.
// - One hysteresis value serves both alert outputs.
// - Halt bit 5 set: finish current conversion, then stop.
// - Halt bit low: convert continuously, no trigger.
// - Halted: only serial port stays alive for accesses.
// - Device is target only, never drives clock.
// - Fast mode to 400 kHz, high speed to 2.56 MHz.
// - Bytes travel MSB first both ways.
// - Start is data falling while clock high.
// - Stop is data rising while clock high.
// - Matching target pulls data low on ninth clock after address.
// - Each byte eight clocks plus receiver acknowledge.
// - Data changes during clock high are start or stop.
// - Writes carry two bytes; commit at second byte acknowledge.
// - First byte after write address is the pointer.
// - Pointer kept across reads; upper byte first.
// - Write ending early leaves register unchanged.
// - Address low bits from strap: ground, supply, data, clock.
`timescale 1ns/1ps
module mct_readout_top (
   input  wire logic                       clk_sys_i,
   input  wire logic                       rst_i,
   input  wire logic                       scl_i,
   input  wire logic                       sda_i,
   output logic                            sda_o,
   output logic                            sda_oe_o,
   input  wire logic                       strap_gnd_i,
   input  wire logic                       strap_vdd_i,
   input  wire logic                       strap_sda_i,
   input  wire logic                       strap_scl_i,
   input  wire mct_pkg::mct_sample_t       local_sample_i,
   input  wire mct_pkg::mct_sample_t [7:0] remote_sample_i,
   input  wire logic [7:0]                 fault_cmp_i,
   output logic                            conv_busy_o,
   output logic                            analog_pwr_en_o,
   output logic                            primary_overtemp_alert_out,
   output logic                            secondary_overtemp_alert_out
);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [1:0] scl_s_q, sda_s_q;
   logic [7:0] flt_s1_q, flt_s2_q;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         scl_s_q  <= 2'b11;
         sda_s_q  <= 2'b11;
         flt_s1_q <= 8'h00;
         flt_s2_q <= 8'h00;
      end else begin
         scl_s_q  <= {scl_s_q[0], scl_i};
         sda_s_q  <= {sda_s_q[0], sda_i};
         flt_s1_q <= fault_cmp_i;
         flt_s2_q <= flt_s1_q;
      end
   end

   // ------------------------------------------------------------------
   // Strap capture after reset release
   // ------------------------------------------------------------------
   logic [1:0] strap_q;
   logic       strap_done_q;
   wire  [1:0] strap_code = strap_vdd_i ? mct_pkg::STRAP_VDD :
                            strap_sda_i ? mct_pkg::STRAP_SDA :
                            strap_scl_i ? mct_pkg::STRAP_SCL : mct_pkg::STRAP_GND;
   wire  [6:0] own_addr   = {mct_pkg::ADDR_HI, strap_q};

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         strap_q      <= 2'b00;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_q      <= strap_code;
         strap_done_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Serial target engine
   // ------------------------------------------------------------------
   logic [7:0]  ptr;
   logic        wr_stb;
   logic [15:0] wr_word;
   logic [15:0] rd_word;

   mct_i2c_target u_target (
      .clk_sys_i  (clk_sys_i),
      .rst_i      (rst_i),
      .scl_i      (scl_s_q[1]),
      .sda_i      (sda_s_q[1]),
      .own_addr_i (own_addr),
      .rd_word_i  (rd_word),
      .sda_oe_o   (sda_oe_o),
      .ptr_o      (ptr),
      .wr_stb_o   (wr_stb),
      .wr_word_o  (wr_word)
   );

   assign sda_o = 1'b0;   // Open drain: only pulls low

   // ------------------------------------------------------------------
   // Writable registers
   // ------------------------------------------------------------------
   logic [15:0] cfg_q, hyst_q, lim1_q, lim2_q;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_q  <= mct_pkg::CONFIG_RST;
         hyst_q <= mct_pkg::HYST_RST;
         lim1_q <= mct_pkg::LIMIT1_RST;
         lim2_q <= mct_pkg::LIMIT2_RST;
      end else if (wr_stb) begin
         if (ptr == mct_pkg::PTR_CONFIG) cfg_q  <= wr_word;
         if (ptr == mct_pkg::PTR_HYST)   hyst_q <= wr_word;
         if (ptr == mct_pkg::PTR_LIMIT1) lim1_q <= wr_word;
         if (ptr == mct_pkg::PTR_LIMIT2) lim2_q <= wr_word;
      end
   end

   wire halt_after_conversion_bit = cfg_q[mct_pkg::CFG_HALT_BIT];

   // ------------------------------------------------------------------
   // Conversion timebase
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      CV_RUN  = 2'b00,
      CV_DONE = 2'b01,
      CV_HALT = 2'b11
   } mct_conv_t;

   mct_conv_t   cv_q;
   logic [16:0] cnt_q;
   wire         conv_end = (cnt_q == 17'(mct_pkg::CONV_CYCLES - 1));

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cv_q  <= CV_RUN;
         cnt_q <= 17'h00000;
      end else begin
         case (cv_q)
            CV_RUN: begin
               cnt_q <= conv_end ? 17'h00000 : cnt_q + 17'h00001;
               if (conv_end) cv_q <= CV_DONE;
            end
            CV_DONE: begin
               cv_q <= halt_after_conversion_bit ? CV_HALT : CV_RUN;
            end
            CV_HALT: begin
               if (!halt_after_conversion_bit) cv_q <= CV_RUN;
            end
            default: cv_q <= CV_RUN;
         endcase
      end
   end

   assign conv_busy_o     = (cv_q == CV_RUN);
   assign analog_pwr_en_o = (cv_q != CV_HALT);

   // ------------------------------------------------------------------
   // Result formatting and fault capture
   // ------------------------------------------------------------------
   function automatic logic [15:0] fmt_temp(input mct_pkg::mct_sample_t s);
      if (s.shorted) fmt_temp = mct_pkg::TEMP_SHORTED;
      else           fmt_temp = {s.value, 3'b000};
   endfunction

   logic [15:0] temp_q [0:mct_pkg::NUM_REMOTE];
   logic [7:0]  flt_acc_q;
   logic [7:0]  remote_open_fault_flag;

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         flt_acc_q <= 8'h00;
         remote_open_fault_flag <= 8'h00;
      end else if (cv_q == CV_RUN) begin
         flt_acc_q <= conv_end ? 8'h00 : flt_acc_q | flt_s2_q;
         if (conv_end) remote_open_fault_flag <= flt_acc_q | flt_s2_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g <= mct_pkg::NUM_REMOTE; g++) begin : g_res
         always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               temp_q[g] <= 16'h0000;
            end else if (cv_q == CV_RUN && conv_end) begin
               temp_q[g] <= fmt_temp(g == 0 ? local_sample_i : remote_sample_i[(g == 0) ? 0 : g - 1]);
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Read multiplexer
   // ------------------------------------------------------------------
   wire is_temp = (ptr <= 8'(mct_pkg::NUM_REMOTE));
   assign rd_word = is_temp                       ? temp_q[ptr[3:0]] :
                    (ptr == mct_pkg::PTR_STATUS)  ? {8'h00, remote_open_fault_flag} :
                    (ptr == mct_pkg::PTR_CONFIG)  ? cfg_q :
                    (ptr == mct_pkg::PTR_HYST)    ? hyst_q :
                    (ptr == mct_pkg::PTR_LIMIT1)  ? lim1_q :
                    (ptr == mct_pkg::PTR_LIMIT2)  ? lim2_q : 16'h0000;

   // ------------------------------------------------------------------
   // Over-temperature alerts with shared hysteresis
   // ------------------------------------------------------------------
   logic [8:0] above1, below1, above2, below2;
   logic       alert1_q, alert2_q;

   generate
      for (g = 0; g <= mct_pkg::NUM_REMOTE; g++) begin : g_cmp
         assign above1[g] = $signed(temp_q[g]) > $signed(lim1_q);
         assign below1[g] = $signed(temp_q[g]) <= $signed(16'(lim1_q - hyst_q));
         assign above2[g] = $signed(temp_q[g]) > $signed(lim2_q);
         assign below2[g] = $signed(temp_q[g]) <= $signed(16'(lim2_q - hyst_q));
      end
   endgenerate

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         alert1_q <= 1'b0;
         alert2_q <= 1'b0;
      end else begin
         if (|above1) alert1_q <= 1'b1;
         else if (&below1) alert1_q <= 1'b0;
         if (|above2) alert2_q <= 1'b1;
         else if (&below2) alert2_q <= 1'b0;
      end
   end

   assign primary_overtemp_alert_out   = alert1_q;
   assign secondary_overtemp_alert_out = alert2_q;

endmodule // mct_readout_top

// ==== tb/mct_readout_assertions.sv ====
// Checker on the readout top pins, bound onto mct_readout_top.
// Assumes bench SCL low and high phases of 8 clocks each.
`timescale 1ns/1ps
module mct_readout_assertions (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic conv_busy_o,
   input wire logic analog_pwr_en_o,
   input wire logic primary_overtemp_alert_out,
   input wire logic secondary_overtemp_alert_out
);
   // ---------------------------------------------
   // Raw start detection and SCL rise count
   // ---------------------------------------------
   logic       scl_q;
   logic       sda_q;
   logic       seen_q;
   logic [3:0] cnt_q;
   wire        start_w = scl_q && scl_i && sda_q && !sda_i;
   wire        rise_w  = scl_i && !scl_q && (cnt_q != 4'hf);
   // Count rises since start, note first drive
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
         seen_q <= 1'b0;
         cnt_q  <= 4'h0;
      end else begin
         scl_q  <= scl_i;
         sda_q  <= sda_i;
         seen_q <= !start_w && (seen_q || sda_oe_o);
         cnt_q  <= start_w ? 4'h0 : cnt_q + {3'h0, rise_w};
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   drain_low_a: assert property (sda_o == 1'b0) else $error("sda driven high");
   rst_quiet_a: assert property ($fell(rst_i) |-> !sda_oe_o [*3]) else $error("drive after reset");
   alert_rst_a: assert property ($fell(rst_i) |-> !primary_overtemp_alert_out
      && !secondary_overtemp_alert_out) else $error("alert after reset");
   oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i) else $error("sda moved, scl high");
   oe_stands_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8]) else $error("drive too short");
   ack_ninth_a: assert property ($rose(sda_oe_o) && !seen_q |-> cnt_q == 4'h8) else $error("ack slot");
   halt_idle_a: assert property (!analog_pwr_en_o |-> !conv_busy_o) else $error("busy while halted");
   halt_end_a: assert property ($fell(analog_pwr_en_o) |-> $past(conv_busy_o, 2)) else $error("halt early");
endmodule // mct_readout_assertions

bind mct_readout_top mct_readout_assertions u_chk (.clk_sys_i, .rst_i, .scl_i, .sda_i, .sda_o,
   .sda_oe_o, .conv_busy_o, .analog_pwr_en_o, .primary_overtemp_alert_out, .secondary_overtemp_alert_out);

// ==== tb/mct_ctl_model.sv ====
// Two-wire bus controller model: makes SCL, start, stop and bits.
// Assumes the bench resolves SDA with a pull-up; SCL idles high.
`timescale 1ns/1ps
module mct_ctl_model (
   input  wire logic clk_sys_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   // ---------------------------------------------
   // Bus cycles, 16 clocks a bit
   // ---------------------------------------------
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   // SDA falls while SCL high
   task automatic start();
      wt(4);
      sda_low_o <= 1'b0;
      wt(4);
      scl_o <= 1'b1;
      wt(4);
      sda_low_o <= 1'b1;
      wt(4);
      scl_o <= 1'b0;
   endtask
   // SDA rises while SCL high, then bus free
   task automatic stop();
      wt(4);
      sda_low_o <= 1'b1;
      wt(4);
      scl_o <= 1'b1;
      wt(4);
      sda_low_o <= 1'b0;
      wt(8);
   endtask
   // Data set mid-low, sampled mid-high
   task automatic bit_x(input logic v, output logic r);
      wt(4);
      sda_low_o <= !v;
      wt(4);
      scl_o <= 1'b1;
      wt(4);
      r = sda_i;
      wt(4);
      scl_o <= 1'b0;
   endtask
   // Eight bits then acknowledge slot
   task automatic xbyte(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
      bit_x(last, ack);
   endtask
endmodule // mct_ctl_model

// ==== tb/multi_channel_temp_target_port_tb_top.sv ====
// Bench for the temperature readout top with a bus controller model.
// Assumes 100 MHz clock and a fixed conversion length from the package.
`timescale 1ns/1ps
module multi_channel_temp_target_port_tb_top;
   logic                       clk_sys_i;
   logic                       rst_i;
   logic [3:0]                 strap;
   logic [6:0]                 addr;
   logic [7:0]                 flt;
   mct_pkg::mct_sample_t       loc;
   mct_pkg::mct_sample_t [7:0] rem;
   wire                        scl_w, ctl_low, sda_o_w, sda_oe_w, busy_w, pwr_w, al1_w, al2_w;
   wire                        sda_w = !ctl_low && (sda_oe_w ? sda_o_w : 1'b1);
   int                         n_fail = 0;
   int                         tests_run = 0;
   int                         cyc = 0;
   // ---------------------------------------------
   // Instances
   // ---------------------------------------------
   mct_ctl_model u_ctl (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl_w), .sda_low_o(ctl_low));
   mct_readout_top u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w),
      .sda_o(sda_o_w), .sda_oe_o(sda_oe_w), .strap_gnd_i(strap[0]), .strap_vdd_i(strap[1]),
      .strap_sda_i(strap[2]), .strap_scl_i(strap[3]), .local_sample_i(loc), .remote_sample_i(rem),
      .fault_cmp_i(flt), .conv_busy_o(busy_w), .analog_pwr_en_o(pwr_w),
      .primary_overtemp_alert_out(al1_w), .secondary_overtemp_alert_out(al2_w));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] exp_w(input mct_pkg::mct_sample_t s);
      return s.shorted ? mct_pkg::TEMP_SHORTED : {s.value, 3'h0};
   endfunction
   task automatic tx(input logic [7:0] b, output logic a);
      logic [7:0] d;
      u_ctl.xbyte(b, 1'b1, d, a);
   endtask
   // Address, pointer, then n data bytes upper first
   task automatic wr(input logic [7:0] p, input logic [15:0] w, input int n);
      logic a;
      u_ctl.start();
      tx({addr, 1'b0}, a);
      chk({15'h0, a}, 16'h0);
      tx(p, a);
      chk({15'h0, a}, 16'h0);
      for (int i = 0; i < n; i++) begin
         tx(i ? w[7:0] : w[15:8], a);
         chk({15'h0, a}, 16'h0);
      end
      u_ctl.stop();
   endtask
   task automatic rd(output logic [15:0] w);
      logic a;
      u_ctl.start();
      tx({addr, 1'b1}, a);
      chk({15'h0, a}, 16'h0);
      u_ctl.xbyte(8'hff, 1'b0, w[15:8], a);
      u_ctl.xbyte(8'hff, 1'b1, w[7:0], a);
      u_ctl.stop();
   endtask
   task automatic rdp(input logic [7:0] p, input logic [15:0] exp);
      logic [15:0] w;
      wr(p, 16'h0, 0);
      rd(w);
      chk(w, exp);
   endtask
   task automatic reset();
      rst_i <= 1'b1;
      u_ctl.wt(2);
      rst_i <= 1'b0;
      u_ctl.wt(6);
   endtask
   // ---------------------------------------------
   // Clock and hang guard
   // ---------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_fail++;
         conclude();
      end
   end
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      logic [15:0] w;
      logic [7:0]  f;
      logic        a;
      rst_i = 1'b1;
      strap = 4'h1;
      addr = 7'h0;
      flt = 8'h0;
      loc = '0;
      rem = '0;
      void'($urandom(42738));
      // Each strap: word write, early stop, kept pointer, foreign address
      for (int s = 0; s < 4; s++) begin
         strap <= 4'h1 << s;
         addr = {mct_pkg::ADDR_HI, 2'(s)};
         reset();
         w = 16'($urandom);
         wr(mct_pkg::PTR_HYST, w, 2);
         rdp(mct_pkg::PTR_HYST, w);
         wr(mct_pkg::PTR_LIMIT2, ~w, 1);
         rdp(mct_pkg::PTR_LIMIT2, mct_pkg::LIMIT2_RST);
         rd(w);
         chk(w, mct_pkg::LIMIT2_RST);
         u_ctl.start();
         tx({~mct_pkg::ADDR_HI, 2'(s), 1'b0}, a);
         chk({15'h0, a}, 16'h1);
         u_ctl.stop();
         $display("test strap %0d done", s);
      end
      // One conversion with halt requested midway
      f = 8'($urandom);
      flt <= f;
      strap <= 4'h1;
      addr = {mct_pkg::ADDR_HI, mct_pkg::STRAP_GND};
      loc <= '{13'h400 + 13'($urandom & 32'h3ff), 1'b0, 1'b0};
      for (int i = 0; i < 8; i++) rem[i] <= '{13'h1000 | 13'($urandom), i == 0, f[i]};
      reset();
      chk({15'h0, busy_w}, 16'h1);
      rdp(mct_pkg::PTR_CONFIG, mct_pkg::CONFIG_RST);
      wr(mct_pkg::PTR_LIMIT1, 16'h1000, 2);
      wr(mct_pkg::PTR_CONFIG, 16'h1 << mct_pkg::CFG_HALT_BIT, 2);
      rdp(mct_pkg::PTR_CONFIG, 16'h1 << mct_pkg::CFG_HALT_BIT);
      u_ctl.wt(mct_pkg::CONV_CYCLES);
      chk({14'h0, pwr_w, busy_w}, 16'h0);
      rdp(mct_pkg::PTR_LOCAL, exp_w(loc));
      for (int i = 0; i < 8; i++) rdp(mct_pkg::PTR_LOCAL + 8'(i + 1), exp_w(rem[i]));
      rdp(mct_pkg::PTR_STATUS, {8'h00, f});
      chk({14'h0, al2_w, al1_w}, 16'h1);
      $display("test conversion done");
      conclude();
   end
endmodule // multi_channel_temp_target_port_tb_top
